// File: core/lane_steer.sv
// quarterword lane placement for sub-word writes and reads
// assumes single and double precision pass whole words unchanged
`timescale 1ns/100ps
module lane_steer
   import align_pkg::*;
(
   input  wire align_pkg::prec_t        prec_in,
   input  wire logic [OFF_W-1:0]        qw_off_in,
   input  wire logic [WORD_W-1:0]       wvalue_in,
   input  wire logic [WORD_W-1:0]       rword_in,
   output logic      [WORD_W-1:0]       wword_out,
   output logic      [LANES-1:0]        lanes_out,
   output logic      [WORD_W-1:0]       rvalue_out
);

   // lowest address is the leftmost lane, so shift counts down
   function automatic logic [5:0] lane_shift(input prec_t p, input logic [OFF_W-1:0] off);
      logic [5:0] s;
      s = 6'h00;
      if (p == quarter_precision)
         s = 6'(QW_W * (3 - int'(off)));
      else if (p == half_precision)
         s = 6'(QW_W * (2 - int'(off)));
      return s;
   endfunction

   logic [5:0]        shift;
   logic [WORD_W-1:0] mask;

   // big endian lane steering both ways
   always_comb begin
      shift     = lane_shift(prec_in, qw_off_in);
      mask      = {WORD_W{1'b1}};
      lanes_out = ALL_LANE;
      if (prec_in == quarter_precision) begin
         mask      = QW_MASK;
         lanes_out = QW_LANE >> qw_off_in;
      end else if (prec_in == half_precision) begin
         mask      = HW_MASK;
         lanes_out = HW_LANE >> qw_off_in;
      end
      wword_out  = (wvalue_in & mask) << shift;
      rvalue_out = (rword_in >> shift) & mask;
   end

endmodule // lane_steer

// File: core/ring_check.sv
// ring rank and privilege checks for one operand access
// assumes ring 0 ranks highest and inputs are stable for the check cycle
`timescale 1ns/100ps
module ring_check
   import align_pkg::*;
(
   input  wire logic [RING_W-1:0]    exec_ring_in,
   input  wire logic [RING_W-1:0]    target_ring_in,
   input  wire logic [RING_W-1:0]    priv_level_in,
   input  wire logic [NUM_RINGS-1:0] protect_in,
   input  wire logic                 priv_op_in,
   output logic                      privileged_out,
   output logic                      priv_trap_out,
   output logic                      ring_trap_out
);

   // lower number is higher rank
   always_comb begin
      privileged_out = (exec_ring_in <= priv_level_in);
      priv_trap_out  = priv_op_in && !privileged_out;
      // only a ring that ranks below the target can be refused
      ring_trap_out  = protect_in[target_ring_in]
                       && (target_ring_in < exec_ring_in);
   end

endmodule // ring_check

// File: core/word_address_align_check.sv
// operand address handling between the pipeline and memory
// assumes requester and memory run on sys_clk_in; no synchronisers needed
`timescale 1ns/100ps
module word_address_align_check
   import align_pkg::*;
(
   input  wire logic                           sys_clk_in,
   input  wire logic                           arst_n_in,
   input  wire logic                           ce_in,
   input  wire logic                           req_valid_in,
   input  wire align_pkg::op_req_t             req_in,
   output logic                                req_ready_out,
   input  wire logic [align_pkg::WORD_W-1:0]   proc_status_in,
   input  wire logic [align_pkg::RING_W-1:0]   exec_ring_in,
   input  wire logic [align_pkg::NUM_RINGS-1:0] ring_protect_in,
   output logic                                mem_valid_out,
   output align_pkg::mem_req_t                 mem_req_out,
   input  wire logic                           mem_ack_in,
   input  wire logic [align_pkg::WORD_W-1:0]   mem_rdata_in,
   output logic                                resp_valid_out,
   output align_pkg::op_resp_t                 resp_out
);

   import align_pkg::*;

   // alignment test on the low quarterword offset bits
   function automatic logic misaligned(input prec_t p, input logic [OFF_W-1:0] off);
      logic bad;
      bad = 1'b0;
      case (p)
         half_precision:   bad = off[0];
         single_precision: bad = (off != '0);
         // a doubleword is two whole singlewords, so the same test holds
         double_precision: bad = (off != '0);
         // a quarterword fits at any address
         default:          bad = 1'b0;
      endcase
      return bad;
   endfunction

   // next singleword inside the same virtual space, wrapping at its top
   function automatic logic [VIDX_W-1:0] next_word(input logic [VIDX_W-1:0] idx);
      return VIDX_W'(idx + 1'b1);
   endfunction

   // physical word address from a virtual singleword index
   function automatic logic [PHYS_W-1:0] phys_word(input logic [VIDX_W-1:0] idx);
      // no translation here: the virtual index is used as is
      return {{(PHYS_W-VIDX_W){1'b0}}, idx};
   endfunction

   // sequencer state and the held request
   state_t             state_ff;
   state_t             nxt_state;
   op_req_t            req_ff;
   op_req_t            nxt_req;

   // status snapshot; later status edits miss this access
   logic [RING_W-1:0]  priv_lvl_ff;
   logic [RING_W-1:0]  nxt_priv_lvl;
   logic [RING_W-1:0]  exec_ring_ff;
   logic [RING_W-1:0]  nxt_exec_ring;
   logic [NUM_RINGS-1:0] protect_ff;
   logic [NUM_RINGS-1:0] nxt_protect;

   // memory port beat
   mem_req_t           mem_ff;
   mem_req_t           nxt_mem;
   logic               mem_valid_ff;
   logic               nxt_mem_valid;

   // answer and handshake to the pipeline
   op_resp_t           resp_ff;
   op_resp_t           nxt_resp;
   logic               resp_valid_ff;
   logic               nxt_resp_valid;
   logic               ready_ff;
   logic               nxt_ready;

   // pointer fields of the held request
   logic [TAG_W-1:0]   tag;
   logic [FIELD_W-1:0] field;
   logic [RING_W-1:0]  target_ring;
   logic [OFF_W-1:0]   qw_off;
   logic [VIDX_W-1:0]  word_idx;

   // pointer split: tag on top, quarterword field below
   assign tag         = req_ff.ptr[TAG_LSB +: TAG_W];
   assign field       = req_ff.ptr[FIELD_W-1:0];
   assign target_ring = tag[TAG_RING_LSB +: RING_W];
   assign qw_off      = field[OFF_W-1:0];
   assign word_idx    = field[FIELD_W-1:OFF_W];

   // steered write word, lanes and read value
   logic [WORD_W-1:0] steer_wword;
   logic [LANES-1:0]  steer_lanes;
   logic [WORD_W-1:0] steer_rvalue;

   // big endian lane placement for sub-word beats
   lane_steer u_lane_steer (
      .prec_in    (req_ff.prec),
      .qw_off_in  (qw_off),
      .wvalue_in  (req_ff.wdata[WORD_W-1:0]),
      .rword_in   (mem_rdata_in),
      .wword_out  (steer_wword),
      .lanes_out  (steer_lanes),
      .rvalue_out (steer_rvalue)
   );

   // ring and privilege results
   logic chk_privileged;
   logic chk_priv_trap;
   logic chk_ring_trap;

   // checks use the snapshot, not the live status
   ring_check u_ring_check (
      .exec_ring_in   (exec_ring_ff),
      .target_ring_in (target_ring),
      .priv_level_in  (priv_lvl_ff),
      .protect_in     (protect_ff),
      .priv_op_in     (req_ff.priv_op),
      .privileged_out (chk_privileged),
      .priv_trap_out  (chk_priv_trap),
      .ring_trap_out  (chk_ring_trap)
   );

   // merged trap view
   logic chk_misalign;
   logic chk_any_trap;
   logic is_double;

   // all three checks land in the same cycle so one trap never masks another
   always_comb begin
      chk_misalign = misaligned(req_ff.prec, qw_off);
      chk_any_trap = chk_misalign || chk_priv_trap || chk_ring_trap;
      is_double    = (req_ff.prec == double_precision);
   end

   // the memory beat for the first singleword of the access
   function automatic mem_req_t first_beat(
      input op_req_t          r,
      input logic [VIDX_W-1:0] idx,
      input logic [RING_W-1:0] ring,
      input logic [FIELD_W-1:0] f,
      input logic [WORD_W-1:0] sub_word,
      input logic [LANES-1:0]  sub_lanes
   );
      mem_req_t m;
      m           = MEM_RST;
      m.word_addr = phys_word(idx);
      m.ring      = ring;
      m.segment   = f[FIELD_W-1:SEG_OFF_W];
      m.offset    = f[SEG_OFF_W-1:0];
      m.write     = r.write;
      m.lanes     = sub_lanes;
      m.wdata     = sub_word;
      m.dw_fast   = 1'b0;
      if (r.prec == double_precision) begin
         // high singleword goes out first, at the lower address
         m.wdata   = r.wdata[DWORD_W-1:WORD_W];
         m.lanes   = ALL_LANE;
         m.dw_fast = ((f[OFF_W:0] & DW_FAST_MASK) == '0);
      end
      return m;
   endfunction

   // sequencing: take, check, one or two beats, answer
   always_comb begin
      nxt_state      = state_ff;
      nxt_req        = req_ff;
      nxt_priv_lvl   = priv_lvl_ff;
      nxt_exec_ring  = exec_ring_ff;
      nxt_protect    = protect_ff;
      nxt_mem        = mem_ff;
      nxt_mem_valid  = mem_valid_ff;
      nxt_resp       = resp_ff;
      nxt_resp_valid = 1'b0;

      case (state_ff)
         // take only while ready is shown
         ST_IDLE: begin
            if (req_valid_in && ready_ff) begin
               // status is sampled with the request, later edits do not apply
               nxt_req       = req_in;
               nxt_priv_lvl  = proc_status_in[PS_PRIV_LO +: RING_W];
               nxt_exec_ring = exec_ring_in;
               nxt_protect   = ring_protect_in;
               nxt_state     = ST_CHECK;
            end
         end

         // every check resolves in this one cycle
         ST_CHECK: begin
            nxt_resp           = RESP_RST;
            nxt_resp.misalign  = chk_misalign;
            nxt_resp.priv_trap = chk_priv_trap;
            nxt_resp.ring_trap = chk_ring_trap;
            if (chk_any_trap) begin
               // a faulted access never reaches the memory port
               nxt_state = ST_RESP;
            end else begin
               // clean access: first beat goes out
               nxt_mem       = first_beat(req_ff, word_idx, target_ring, field,
                                          steer_wword, steer_lanes);
               nxt_mem_valid = 1'b1;
               nxt_state     = ST_BEAT0;
            end
         end

         // first or only beat, held until acked
         ST_BEAT0: begin
            if (mem_ack_in) begin
               if (is_double) begin
                  nxt_resp.rdata[DWORD_W-1:WORD_W] = mem_rdata_in;
                  // second beat: next singleword, low half
                  nxt_mem.word_addr = phys_word(next_word(word_idx));
                  nxt_mem.wdata     = req_ff.wdata[WORD_W-1:0];
                  nxt_state         = ST_BEAT1;
               end else begin
                  // sub-word reads come back right justified, zero filled
                  nxt_resp.rdata = {{WORD_W{1'b0}}, steer_rvalue};
                  nxt_mem_valid  = 1'b0;
                  nxt_state      = ST_RESP;
               end
            end
         end

         // low singleword of a doubleword
         ST_BEAT1: begin
            if (mem_ack_in) begin
               nxt_resp.rdata[WORD_W-1:0] = mem_rdata_in;
               nxt_mem_valid = 1'b0;
               nxt_state     = ST_RESP;
            end
         end

         // one-cycle answer pulse
         ST_RESP: begin
            nxt_resp_valid = 1'b1;
            nxt_state      = ST_IDLE;
         end
         default: begin
            nxt_state     = ST_IDLE;
            nxt_mem_valid = 1'b0;
         end
      endcase

      // ready only while the next cycle is idle, so no request is dropped
      nxt_ready = (nxt_state == ST_IDLE);
   end

   // registers; clock enable low freezes everything
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_ff      <= ST_IDLE;
         req_ff        <= REQ_RST;
         priv_lvl_ff   <= '0;
         exec_ring_ff  <= '0;
         protect_ff    <= '0;
         mem_ff        <= MEM_RST;
         mem_valid_ff  <= 1'b0;
         resp_ff       <= RESP_RST;
         resp_valid_ff <= 1'b0;
         ready_ff      <= READY_RST;
      end else if (ce_in) begin
         state_ff      <= nxt_state;
         req_ff        <= nxt_req;
         priv_lvl_ff   <= nxt_priv_lvl;
         exec_ring_ff  <= nxt_exec_ring;
         protect_ff    <= nxt_protect;
         mem_ff        <= nxt_mem;
         mem_valid_ff  <= nxt_mem_valid;
         resp_ff       <= nxt_resp;
         resp_valid_ff <= nxt_resp_valid;
         ready_ff      <= nxt_ready;
      end
   end

   // outputs straight from flops
   assign req_ready_out  = ready_ff;
   assign mem_valid_out  = mem_valid_ff;
   assign mem_req_out    = mem_ff;
   assign resp_valid_out = resp_valid_ff;
   assign resp_out       = resp_ff;

endmodule // word_address_align_check

// File: pkg/align_pkg.sv
// shared constants, modes and carriers for the operand address checker
// assumes one processor clock; all request and memory signals live on it
package align_pkg;

   // word geometry, doc bit 0 (msb) maps to verilog bit 35
   localparam int WORD_W      = 36;
   localparam int DWORD_W     = 72;
   localparam int QW_W        = 9;
   localparam int LANES       = 4;
   localparam int OFF_W       = 2;

   // pointer layout: tag in the top five bits, quarterword field below
   localparam int TAG_W       = 5;
   localparam int FIELD_W     = 31;
   localparam int TAG_LSB     = 31;
   localparam int RING_W      = 2;
   localparam int NUM_RINGS   = 4;
   localparam int TAG_RING_LSB = 0;

   // singleword index in a virtual space, and physical word address
   localparam int VIDX_W      = FIELD_W - OFF_W;
   localparam int PHYS_W      = 32;

   // segment split of the quarterword field
   localparam int SEG_OFF_W   = 18;
   localparam int SEG_W       = FIELD_W - SEG_OFF_W;

   // privilege field position inside the processor status word
   localparam int PS_PRIV_LO  = 31;

   // lane masks and alignment masks
   localparam logic [WORD_W-1:0] QW_MASK  = 36'h0000001FF;
   localparam logic [WORD_W-1:0] HW_MASK  = 36'h00003FFFF;
   localparam logic [LANES-1:0]  QW_LANE  = 4'h8;
   localparam logic [LANES-1:0]  HW_LANE  = 4'hC;
   localparam logic [LANES-1:0]  ALL_LANE = 4'hF;
   localparam logic [OFF_W:0]    DW_FAST_MASK = 3'h7;

   typedef enum logic [1:0] {
      quarter_precision = 2'b00,
      half_precision    = 2'b01,
      single_precision  = 2'b10,
      double_precision  = 2'b11
   } prec_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CHECK = 3'b001,
      ST_BEAT0 = 3'b010,
      ST_BEAT1 = 3'b011,
      ST_RESP  = 3'b100
   } state_t;

   typedef struct packed {
      prec_t               prec;
      logic                write;
      logic                priv_op;
      logic [WORD_W-1:0]   ptr;
      logic [DWORD_W-1:0]  wdata;
   } op_req_t;

   typedef struct packed {
      logic [PHYS_W-1:0]    word_addr;
      logic [RING_W-1:0]    ring;
      logic [SEG_W-1:0]     segment;
      logic [SEG_OFF_W-1:0] offset;
      logic [LANES-1:0]     lanes;
      logic                 write;
      logic [WORD_W-1:0]    wdata;
      logic                 dw_fast;
   } mem_req_t;

   typedef struct packed {
      logic [DWORD_W-1:0]  rdata;
      logic                misalign;
      logic                priv_trap;
      logic                ring_trap;
   } op_resp_t;

   // values after reset
   localparam op_req_t  REQ_RST   = '0;
   localparam mem_req_t MEM_RST   = '0;
   localparam op_resp_t RESP_RST  = '0;
   localparam logic     READY_RST = 1'b0;

endpackage

// File: test/align_monitor.sv
// port-level checks for the operand address checker
// assumes it is bound to word_address_align_check; one clock, async reset
`timescale 1ns/100ps
module align_monitor
   import align_pkg::*;
(
   input  wire logic                            sys_clk_in,
   input  wire logic                            arst_n_in,
   input  wire logic                            ce_in,
   input  wire logic                            req_valid_in,
   input  wire align_pkg::op_req_t              req_in,
   input  wire logic                            req_ready_out,
   input  wire logic [align_pkg::WORD_W-1:0]    proc_status_in,
   input  wire logic [align_pkg::RING_W-1:0]    exec_ring_in,
   input  wire logic [align_pkg::NUM_RINGS-1:0] ring_protect_in,
   input  wire logic                            mem_valid_out,
   input  wire align_pkg::mem_req_t             mem_req_out,
   input  wire logic                            mem_ack_in,
   input  wire logic [align_pkg::WORD_W-1:0]    mem_rdata_in,
   input  wire logic                            resp_valid_out,
   input  wire align_pkg::op_resp_t             resp_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   logic               take;
   logic               clean;
   logic [1:0]         lvl;
   logic [FIELD_W-1:0] f_ff;
   prec_t              p_ff;
   logic [RING_W-1:0]  t_ff;

   // request acceptance and the no-trap condition
   assign take  = ce_in && req_valid_in && req_ready_out;
   assign lvl   = proc_status_in[PS_PRIV_LO+1:PS_PRIV_LO];
   assign clean = !req_in.priv_op && ring_protect_in == 4'h0;

   // hold the taken field so beats can be traced back to their request
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         f_ff <= '0;
         p_ff <= quarter_precision;
         t_ff <= '0;
      end else if (take) begin
         f_ff <= req_in.ptr[FIELD_W-1:0];
         p_ff <= req_in.prec;
         t_ff <= req_in.ptr[32:31];
      end
   end

   property p_half_mis;
      take && req_in.prec == half_precision && req_in.ptr[0]
         |-> ##3 resp_valid_out && resp_out.misalign;
   endproperty
   property p_single_mis;
      take && req_in.prec == single_precision && req_in.ptr[1:0] != 2'h0
         |-> ##3 resp_valid_out && resp_out.misalign;
   endproperty
   property p_double_any;
      take && clean && req_in.prec == double_precision && req_in.ptr[1:0] == 2'h0
         |-> ##2 mem_valid_out && mem_req_out.dw_fast == !f_ff[2];
   endproperty
   property p_priv;
      take && req_in.priv_op && exec_ring_in > lvl |-> ##3 resp_valid_out && resp_out.priv_trap;
   endproperty
   property p_priv_ok;
      take && req_in.priv_op && exec_ring_in <= lvl && ring_protect_in == 4'h0
         && req_in.ptr[1:0] == 2'h0 |-> ##2 mem_valid_out;
   endproperty
   property p_ring;
      take && ring_protect_in[req_in.ptr[32:31]] && req_in.ptr[32:31] < exec_ring_in
         |-> ##3 resp_valid_out && resp_out.ring_trap;
   endproperty
   property p_no_beat;
      resp_valid_out && (resp_out.misalign || resp_out.priv_trap || resp_out.ring_trap)
         |-> !mem_valid_out && !$past(mem_valid_out);
   endproperty
   property p_addr;
      $rose(mem_valid_out) |-> mem_req_out.word_addr == {3'h0, f_ff[FIELD_W-1:OFF_W]};
   endproperty
   property p_seg;
      $rose(mem_valid_out) |-> {mem_req_out.segment, mem_req_out.offset} == f_ff
         && mem_req_out.ring == t_ff;
   endproperty
   property p_lane;
      $rose(mem_valid_out) && p_ff == quarter_precision
         |-> mem_req_out.lanes == (4'h8 >> f_ff[1:0]);
   endproperty
   property p_beat1;
      mem_valid_out && mem_ack_in && p_ff == double_precision
         && mem_req_out.word_addr[28:0] == f_ff[FIELD_W-1:OFF_W]
         |=> mem_valid_out
         && mem_req_out.word_addr[28:0] == $past(mem_req_out.word_addr[28:0]) + 29'h1;
   endproperty

   a_half_mis: assert property (p_half_mis) else $error("odd half not trapped");
   a_single_mis: assert property (p_single_mis) else $error("single not trapped");
   a_double_any: assert property (p_double_any) else $error("double beat wrong");
   a_priv: assert property (p_priv) else $error("user ring priv op passed");
   a_priv_ok: assert property (p_priv_ok) else $error("privileged ring refused");
   a_ring: assert property (p_ring) else $error("protected ring reached");
   a_no_beat: assert property (p_no_beat) else $error("trapped access used memory");
   a_addr: assert property (p_addr) else $error("word address wrong");
   a_seg: assert property (p_seg) else $error("segment split wrong");
   a_lane: assert property (p_lane) else $error("quarter lane wrong");
   a_beat1: assert property (p_beat1) else $error("second beat address wrong");

   c_mis: cover property (resp_valid_out && resp_out.misalign);
   c_priv: cover property (resp_valid_out && resp_out.priv_trap);
   c_dbl: cover property (mem_valid_out && mem_ack_in && p_ff == double_precision);
endmodule // align_monitor

// File: test/mem_model.sv
// word memory standing behind the checker's memory port
// assumes beats hold steady until acked; 16 words, low address bits only
`timescale 1ns/100ps
module mem_model
   import align_pkg::*;
(
   input  wire logic                         sys_clk_in,
   input  wire logic                         arst_n_in,
   input  wire logic [1:0]                   stall_in,
   input  wire logic                         mem_valid_in,
   input  wire align_pkg::mem_req_t          mem_req_in,
   output logic                              mem_ack_out,
   output logic [align_pkg::WORD_W-1:0]      mem_rdata_out
);
   logic [WORD_W-1:0] mem [16];
   logic [WORD_W-1:0] rd_ff;
   logic [1:0]        wait_ff;
   logic [3:0]        idx;

   assign idx = mem_req_in.word_addr[3:0];
   // data is only valid with ack; inverted otherwise so stale reads show
   assign mem_rdata_out = mem_ack_out ? rd_ff : ~rd_ff;

   // ack after a variable stall; write lanes at the accepted edge
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mem_ack_out <= 1'b0;
         wait_ff <= 2'h0;
         rd_ff <= '0;
      end else if (mem_ack_out) begin
         mem_ack_out <= 1'b0;
         wait_ff <= 2'h0;
         for (int k = 0; k < LANES; k++) begin
            if (mem_req_in.write && mem_req_in.lanes[k])
               mem[idx][9*k+:9] <= mem_req_in.wdata[9*k+:9];
         end
      end else if (mem_valid_in) begin
         if (wait_ff >= stall_in) begin
            mem_ack_out <= 1'b1;
            rd_ff <= mem[idx];
         end else
            wait_ff <= wait_ff + 2'h1;
      end
   end
endmodule // mem_model

// File: test/word_address_align_check_test.sv
// self-checking bench for the operand address checker
// assumes align_pkg, align_monitor and mem_model are compiled first
`timescale 1ns/100ps
module word_address_align_check_test;
   import align_pkg::*;
   typedef struct packed {op_resp_t r; logic chk;} note_t;
   logic        sys_clk_in, arst_n_in, ce_in, req_valid_in, req_ready_out;
   logic        mem_valid_out, mem_ack_in, resp_valid_out;
   op_req_t     req_in;
   mem_req_t    mem_req_out;
   op_resp_t    resp_out;
   logic [35:0] proc_status_in, mem_rdata_in;
   logic [35:0] mirror [16];
   logic [1:0]  exec_ring_in, stall;
   logic [3:0]  ring_protect_in;
   logic [63:0] seed = 64'h24;
   logic [63:0] x;
   note_t       exp_q[$];
   note_t       nw;
   int          errors = 0, total_checks = 0, cyc = 0;

   word_address_align_check uut (.sys_clk_in, .arst_n_in, .ce_in, .req_valid_in, .req_in,
      .req_ready_out, .proc_status_in, .exec_ring_in, .ring_protect_in, .mem_valid_out,
      .mem_req_out, .mem_ack_in, .mem_rdata_in, .resp_valid_out, .resp_out);
   mem_model mem (.sys_clk_in, .arst_n_in, .stall_in(stall), .mem_valid_in(mem_valid_out),
      .mem_req_in(mem_req_out), .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));

   always #20 sys_clk_in = ~sys_clk_in;

   function automatic logic [63:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 7);
      seed = seed ^ (seed << 17);
      return seed;
   endfunction

   // pointer with random upper bits, given ring and low field bits
   function automatic logic [35:0] mk(input logic [1:0] t, input logic [5:0] f);
      logic [63:0] y;
      y = rnd();
      return {y[2:0], t, y[27:3], f};
   endfunction

   // note the expected answer, then present one request until taken
   task automatic go(input prec_t p, input logic w, pv, input logic [35:0] pt,
                     input logic [71:0] d);
      logic [3:0]  i;
      logic [5:0]  sh;
      logic [35:0] m;
      note_t       n;
      i = pt[5:2];
      sh = (p == quarter_precision) ? 6'h1B - 6'h09 * pt[1:0] :
           (p == half_precision) ? 6'h12 - 6'h09 * pt[1:0] : 6'h00;
      m = (p == quarter_precision) ? QW_MASK << sh : (p == half_precision) ? HW_MASK << sh : '1;
      n.r = '0;
      n.r.misalign = (p == half_precision) ? pt[0] : (p != quarter_precision && pt[1:0] != 2'h0);
      n.r.priv_trap = pv && exec_ring_in > proc_status_in[32:31];
      n.r.ring_trap = ring_protect_in[pt[32:31]] && pt[32:31] < exec_ring_in;
      n.chk = !w && n.r[2:0] == 3'h0;
      n.r.rdata = (p == double_precision) ? {mirror[i], mirror[i+4'h1]} :
                  {36'h0, (mirror[i] & m) >> sh};
      if (w && n.r[2:0] == 3'h0) begin
         if (p == double_precision) begin
            mirror[i] = d[71:36];
            mirror[i+4'h1] = d[35:0];
         end else
            mirror[i] = (mirror[i] & ~m) | ((d[35:0] << sh) & m);
      end
      exp_q.push_back(n);
      x = rnd();
      stall = x[1:0];
      @(posedge sys_clk_in);
      #1;
      req_in = '{p, w, pv, pt, d};
      req_valid_in = 1'b1;
      do @(posedge sys_clk_in); while (req_ready_out !== 1'b1);
      #1;
      req_valid_in = 1'b0;
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // pair each response pulse with the oldest note; rdata only for clean reads
   always @(posedge sys_clk_in) begin
      if (resp_valid_out === 1'b1) begin
         total_checks++;
         if (exp_q.size() == 0) begin
            errors++;
            $display("MISMATCH resp expected none seen %h", resp_out);
         end else begin
            nw = exp_q.pop_front();
            if (nw.chk ? resp_out !== nw.r : resp_out[2:0] !== nw.r[2:0]) begin
               errors++;
               $display("MISMATCH resp expected %h seen %h", nw.r, resp_out);
            end
         end
      end
   end

   // hang guard, well above the roughly 800 cycles the run needs
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 8000) begin
         errors++;
         close_out();
      end
   end

   initial begin
      sys_clk_in = 1'b0;
      arst_n_in = 1'b0;
      ce_in = 1'b1;
      req_valid_in = 1'b0;
      req_in = '0;
      proc_status_in = '0;
      exec_ring_in = 2'h0;
      ring_protect_in = 4'h0;
      stall = 2'h0;
      repeat (2) @(posedge sys_clk_in);
      total_checks++;
      if ({req_ready_out, mem_valid_out, resp_valid_out} !== 3'h0) begin
         errors++;
         $display("MISMATCH reset outputs expected 000 seen %b",
                  {req_ready_out, mem_valid_out, resp_valid_out});
      end
      #1;
      arst_n_in = 1'b1;
      // known contents first, so later reads have defined answers
      for (int k = 0; k < 16; k++) begin
         x = rnd();
         go(single_precision, 1'b1, 1'b0, mk(2'h0, 6'(k * 4)), 72'(x));
      end
      // a waiting request must not be taken while the enable is low
      while (exp_q.size() != 0) @(posedge sys_clk_in);
      #1;
      ce_in = 1'b0;
      req_valid_in = 1'b1;
      repeat (3) @(posedge sys_clk_in);
      total_checks++;
      if ({mem_valid_out, req_ready_out} !== 2'h1) begin
         errors++;
         $display("MISMATCH frozen outputs expected 01 seen %b", {mem_valid_out, req_ready_out});
      end
      #1;
      ce_in = 1'b1;
      req_valid_in = 1'b0;
      // every precision, offset and direction at random words
      for (int k = 0; k < 64; k++) begin
         x = rnd();
         go(prec_t'(k[1:0]), k[2], 1'b0, mk(x[9:8], {x[3:0], k[4:3]}), {x, x[7:0]});
      end
      // ring of execution, target ring and privilege level combinations
      for (int k = 0; k < 64; k++) begin
         x = rnd();
         exec_ring_in = k[1:0];
         proc_status_in = {x[35:33], k[5:4], x[30:0]};
         ring_protect_in = k[0] ? x[39:36] : 4'h0;
         go(single_precision, 1'b0, x[40], mk(k[3:2], {x[44:41], 2'h0}), 72'h0);
      end
      while (exp_q.size() != 0) @(posedge sys_clk_in);
      repeat (4) @(posedge sys_clk_in);
      close_out();
   end
endmodule // word_address_align_check_test

bind word_address_align_check align_monitor chk (.sys_clk_in, .arst_n_in, .ce_in,
   .req_valid_in, .req_in, .req_ready_out, .proc_status_in, .exec_ring_in,
   .ring_protect_in, .mem_valid_out, .mem_req_out, .mem_ack_in, .mem_rdata_in,
   .resp_valid_out, .resp_out);
